// ---- include/glue_pkg.sv ----
package glue_pkg;
  // I/O port addresses of the register bank.
  localparam logic [7:0] VIDEO_STATUS_PORT = 8'h30;
  localparam logic [7:0] CURSOR_COLUMN_PORT = 8'h31;
  localparam logic [7:0] CURSOR_LINE_PORT = 8'h32;
  localparam logic [7:0] VIDEO_WRITE_DATA_PORT = 8'h33;
  localparam logic [7:0] SYSTEM_CONTROL_PORT = 8'h34;
  localparam logic [7:0] KEYBOARD_STATUS_PORT = 8'h35;
  localparam logic [7:0] KEYBOARD_CODE_PORT = 8'h36;
  // Decoded peripheral blocks.
  localparam logic [7:0] VIDEO_CTRL_BASE = 8'h80;
  localparam logic [7:0] VIDEO_CTRL_MASK = 8'hf0;
  localparam logic [7:0] PARALLEL_BASE = 8'h08;
  localparam logic [7:0] PARALLEL_MASK = 8'hfc;
  // Memory map.
  localparam logic [15:0] BOOT_LIMIT = 16'h1000;
  localparam int BOOT_ADDR_W = 12;
  // Field positions.
  localparam int SYSCTL_BOOT_OFF_BIT = 7;
  localparam int SYSCTL_BEEP_BIT = 6;
  localparam int KBD_PRESS_BIT = 7;
  localparam int KBD_ALPHA_BIT = 6;
  localparam int KBD_CTRL_BIT = 1;
  localparam int KBD_SHIFT_BIT = 0;
  localparam int VIDEO_READY_BIT = 7;
  localparam int PRN_STROBE_BIT = 1;
  localparam int PRN_BUSY_BIT = 2;
  localparam int PRN_PAPER_BIT = 3;
  localparam int PRN_ONLINE_BIT = 4;
  localparam int PRN_FAULT_BIT = 5;
  // Widths, reset values and the unmapped-port read value.
  localparam int COLUMN_W = 7;
  localparam int LINE_W = 6;
  localparam int KEY_W = 7;
  localparam logic [7:0] SYSCTL_RESET = 8'h00;
  localparam logic [7:0] ZERO_BYTE = 8'h00;
  localparam logic [7:0] OPEN_BUS = 8'hff;

  typedef struct packed {
    logic [15:0] addr;
    logic [7:0] wdata;
    logic mem_rd;
    logic mem_wr;
    logic io_rd;
    logic io_wr;
  } cpu_req_t;

  typedef struct packed {
    logic [COLUMN_W-1:0] column;
    logic [LINE_W-1:0] line;
    logic [7:0] data;
    logic we;
  } video_wr_t;

  typedef struct packed {
    logic alpha_lock;
    logic ctrl_key;
    logic shift_key;
  } key_mods_t;
endpackage

// ---- hdl/io_decoder.sv ----
`timescale 1ns/100ps
module io_decoder (
  // Port address.
  input wire logic [7:0] port_addr,
  input wire logic io_cycle,
  // Chip selects.
  output logic video_ctrl_sel,
  output logic parallel_sel
);
  import glue_pkg::*;

  always_comb begin
    video_ctrl_sel = io_cycle && ((port_addr & VIDEO_CTRL_MASK) == VIDEO_CTRL_BASE);
    parallel_sel = io_cycle && ((port_addr & PARALLEL_MASK) == PARALLEL_BASE);
  end
endmodule

// ---- hdl/memory_overlay.sv ----
`timescale 1ns/100ps
module memory_overlay (
  // Processor memory cycle.
  input wire logic [15:0] addr,
  input wire logic mem_rd,
  input wire logic mem_wr,
  input wire logic boot_off,
  // Memory selects.
  output logic boot_rom_sel,
  output logic ram_rd_sel,
  output logic ram_wr_sel
);
  import glue_pkg::*;

  logic low_region;

  always_comb begin
    low_region = addr < BOOT_LIMIT;
    boot_rom_sel = mem_rd && low_region && !boot_off;
    ram_rd_sel = mem_rd && !(low_region && !boot_off);
    ram_wr_sel = mem_wr;
  end
endmodule

// ---- hdl/system_io_glue_registers.sv ----
`timescale 1ns/100ps
module system_io_glue_registers (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // Processor bus.
  input wire glue_pkg::cpu_req_t cpu,
  output logic [7:0] io_rdata,
  output logic io_rdata_valid,
  // Memory selects.
  output logic boot_rom_sel,
  output logic ram_rd_sel,
  output logic ram_wr_sel,
  // Peripheral selects.
  output logic video_ctrl_sel,
  output logic parallel_sel,
  // Keyboard scanner.
  input wire logic [glue_pkg::KEY_W-1:0] key_code,
  input wire logic key_strobe,
  input wire glue_pkg::key_mods_t key_mods,
  // Video buffer.
  input wire logic video_ready,
  output glue_pkg::video_wr_t video_wr,
  // Beeper.
  output logic beeper_on,
  // Printer control port lines.
  output logic [7:0] printer_ctrl_out,
  input wire logic [7:0] printer_ctrl_in
);
  import glue_pkg::*;

  logic [7:0] system_control_ff;
  logic [COLUMN_W-1:0] cursor_column_ff;
  logic [LINE_W-1:0] cursor_line_ff;
  logic [KEY_W-1:0] key_code_ff;
  logic key_press_ff;
  logic [7:0] io_rdata_ff;
  logic io_rdata_valid_ff;
  video_wr_t video_wr_ff;
  logic [7:0] nxt_rdata;
  logic wr_sysctl;
  logic wr_column;
  logic wr_line;
  logic wr_video;
  logic rd_code;
  logic [7:0] keyboard_status;
  logic [7:0] video_status;

  memory_overlay u_overlay (
    .addr(cpu.addr),
    .mem_rd(cpu.mem_rd),
    .mem_wr(cpu.mem_wr),
    .boot_off(system_control_ff[SYSCTL_BOOT_OFF_BIT]),
    .boot_rom_sel(boot_rom_sel),
    .ram_rd_sel(ram_rd_sel),
    .ram_wr_sel(ram_wr_sel)
  );

  io_decoder u_io_decoder (
    .port_addr(cpu.addr[7:0]),
    .io_cycle(cpu.io_rd || cpu.io_wr),
    .video_ctrl_sel(video_ctrl_sel),
    .parallel_sel(parallel_sel)
  );

  always_comb begin
    wr_sysctl = cpu.io_wr && (cpu.addr[7:0] == SYSTEM_CONTROL_PORT);
    wr_column = cpu.io_wr && (cpu.addr[7:0] == CURSOR_COLUMN_PORT);
    wr_line = cpu.io_wr && (cpu.addr[7:0] == CURSOR_LINE_PORT);
    wr_video = cpu.io_wr && (cpu.addr[7:0] == VIDEO_WRITE_DATA_PORT);
    rd_code = cpu.io_rd && (cpu.addr[7:0] == KEYBOARD_CODE_PORT);
  end

  // System control port: boot unmap and beeper.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      system_control_ff <= SYSCTL_RESET;
    end else if (wr_sysctl) begin
      system_control_ff <= cpu.wdata;
    end
  end

  assign beeper_on = system_control_ff[SYSCTL_BEEP_BIT];

  // Cursor registers.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cursor_column_ff <= '0;
    end else if (wr_column) begin
      cursor_column_ff <= cpu.wdata[COLUMN_W-1:0];
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cursor_line_ff <= '0;
    end else if (wr_line) begin
      cursor_line_ff <= cpu.wdata[LINE_W-1:0];
    end
  end

  // Video buffer write: one-cycle strobe with the cursor address.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      video_wr_ff <= '0;
    end else begin
      video_wr_ff.we <= wr_video;
      if (wr_video) begin
        video_wr_ff.column <= cursor_column_ff;
        video_wr_ff.line <= cursor_line_ff;
        video_wr_ff.data <= cpu.wdata;
      end
    end
  end

  assign video_wr = video_wr_ff;

  // Key code capture; a held flag keeps the first unread code. Set wins over read.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      key_press_ff <= 1'b0;
      key_code_ff <= '0;
    end else if (key_strobe && (!key_press_ff || rd_code)) begin
      key_press_ff <= 1'b1;
      key_code_ff <= key_code;
    end else if (rd_code) begin
      key_press_ff <= 1'b0;
    end
  end

  always_comb begin
    keyboard_status = ZERO_BYTE;
    keyboard_status[KBD_PRESS_BIT] = key_press_ff;
    keyboard_status[KBD_ALPHA_BIT] = key_mods.alpha_lock;
    keyboard_status[KBD_CTRL_BIT] = key_mods.ctrl_key;
    keyboard_status[KBD_SHIFT_BIT] = key_mods.shift_key;
    video_status = ZERO_BYTE;
    video_status[VIDEO_READY_BIT] = video_ready;
  end

  // Read multiplexer for the register bank.
  always_comb begin
    nxt_rdata = OPEN_BUS;
    case (cpu.addr[7:0])
      VIDEO_STATUS_PORT: nxt_rdata = video_status;
      CURSOR_COLUMN_PORT: nxt_rdata = {1'b0, cursor_column_ff};
      CURSOR_LINE_PORT: nxt_rdata = {2'b00, cursor_line_ff};
      SYSTEM_CONTROL_PORT: nxt_rdata = system_control_ff;
      KEYBOARD_STATUS_PORT: nxt_rdata = keyboard_status;
      KEYBOARD_CODE_PORT: nxt_rdata = {1'b0, key_code_ff};
      default: nxt_rdata = OPEN_BUS;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      io_rdata_ff <= ZERO_BYTE;
      io_rdata_valid_ff <= 1'b0;
    end else begin
      io_rdata_valid_ff <= cpu.io_rd;
      if (cpu.io_rd) begin
        io_rdata_ff <= nxt_rdata;
      end
    end
  end

  assign io_rdata = io_rdata_ff;
  assign io_rdata_valid = io_rdata_valid_ff;

  // Printer control port lines: strobe bit copied from printer_ctrl_in to printer_ctrl_out; status bits unused.
  always_comb begin
    printer_ctrl_out = ZERO_BYTE;
    printer_ctrl_out[PRN_STROBE_BIT] = printer_ctrl_in[PRN_STROBE_BIT];
  end
endmodule

// ---- testbench/glue_assertions.sv ----
`timescale 1ns/100ps
module glue_assertions (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // Watched ports.
  input wire glue_pkg::cpu_req_t cpu,
  input wire logic [7:0] io_rdata,
  input wire logic boot_rom_sel,
  input wire logic ram_rd_sel,
  input wire logic ram_wr_sel,
  input wire logic video_ctrl_sel,
  input wire logic parallel_sel,
  input wire logic video_ready,
  input wire glue_pkg::video_wr_t video_wr,
  input wire logic beeper_on
);
  import glue_pkg::*;
  logic off_ff;
  wire logic io_cyc = cpu.io_rd | cpu.io_wr;
  // Shadow of the boot-store disable bit, rebuilt from the bus.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      off_ff <= 1'b0;
    end else if (cpu.io_wr && cpu.addr[7:0] == SYSTEM_CONTROL_PORT) begin
      off_ff <= cpu.wdata[SYSCTL_BOOT_OFF_BIT];
    end
  end
  sequence wr_at(logic [7:0] p);
    cpu.io_wr && cpu.addr[7:0] == p;
  endsequence
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  boot_read_a: assert property (
    cpu.mem_rd && cpu.addr < BOOT_LIMIT && !off_ff |-> boot_rom_sel && !ram_rd_sel)
    else $error("Low read missed the boot store.");
  ram_read_a: assert property (
    cpu.mem_rd && (cpu.addr >= BOOT_LIMIT || off_ff) |-> ram_rd_sel && !boot_rom_sel)
    else $error("Read missed RAM.");
  ram_write_a: assert property (cpu.mem_wr |-> ram_wr_sel && !boot_rom_sel)
    else $error("Write missed RAM.");
  video_store_a: assert property (
    wr_at(VIDEO_WRITE_DATA_PORT) |=> video_wr.we && video_wr.data == $past(cpu.wdata))
    else $error("Video byte not stored.");
  beep_follow_a: assert property (
    wr_at(SYSTEM_CONTROL_PORT) |=> beeper_on == $past(cpu.wdata[SYSCTL_BEEP_BIT]))
    else $error("Beeper does not follow its bit.");
  video_decode_a: assert property (video_ctrl_sel == (io_cyc && cpu.addr[7:4] == 4'h8))
    else $error("Video controller select wrong.");
  par_decode_a: assert property (parallel_sel == (io_cyc && cpu.addr[7:2] == 6'h02))
    else $error("Parallel select wrong.");
  reset_clear_a: assert property ($rose(rst_n) |-> !beeper_on && !video_wr.we)
    else $error("Outputs not cleared by reset.");
  ready_read_a: assert property (
    cpu.io_rd && cpu.addr[7:0] == VIDEO_STATUS_PORT |=> io_rdata[7] == $past(video_ready))
    else $error("Ready flag misread.");
endmodule
bind system_io_glue_registers glue_assertions chk_u (.clk, .rst_n, .cpu, .io_rdata, .boot_rom_sel, .ram_rd_sel,
  .ram_wr_sel, .video_ctrl_sel, .parallel_sel, .video_ready, .video_wr, .beeper_on);

// ---- testbench/video_buffer_model.sv ----
`timescale 1ns/100ps
module video_buffer_model (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // Buffer side.
  input wire glue_pkg::video_wr_t video_wr,
  output logic video_ready
);
  import glue_pkg::*;
  logic [1:0] busy_ff;
  // Each stored byte keeps the buffer busy for three cycles.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      busy_ff <= 2'h0;
    end else if (video_wr.we) begin
      busy_ff <= 2'h3;
    end else if (busy_ff != 2'h0) begin
      busy_ff <= busy_ff - 2'h1;
    end
  end
  assign video_ready = (busy_ff == 2'h0);
endmodule

// ---- testbench/system_io_glue_registers_tb.sv ----
`timescale 1ns/100ps
module system_io_glue_registers_tb;
  import glue_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  cpu_req_t cpu = '0;
  logic [6:0] key_code = 7'h00;
  logic key_strobe = 1'b0;
  key_mods_t key_mods = '0;
  logic [7:0] prn_in = 8'h00;
  logic [7:0] io_rdata, prn_out;
  logic io_rdata_valid, boot_rom_sel, ram_rd_sel, ram_wr_sel, video_ctrl_sel, parallel_sel, video_ready, beeper_on;
  video_wr_t video_wr;
  int n_errors = 0;
  int total_checks = 0;
  always #20 clk = ~clk;
  system_io_glue_registers dut_u (.clk, .rst_n, .cpu, .io_rdata, .io_rdata_valid, .boot_rom_sel, .ram_rd_sel,
    .ram_wr_sel, .video_ctrl_sel, .parallel_sel, .key_code, .key_strobe, .key_mods, .video_ready, .video_wr,
    .beeper_on, .printer_ctrl_out(prn_out), .printer_ctrl_in(prn_in));
  video_buffer_model buf_u (.clk, .rst_n, .video_wr, .video_ready);
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic io(input logic wr, input logic [7:0] port, input logic [7:0] d);
    @(posedge clk) #1;
    cpu = '0;
    cpu.addr = {8'h00, port};
    cpu.wdata = d;
    cpu.io_wr = wr;
    cpu.io_rd = !wr;
    @(posedge clk) #1;
    cpu = '0;
  endtask
  task automatic rdchk(input string what, input logic [7:0] port, input logic [7:0] exp);
    io(1'b0, port, 8'h00);
    chk(what, exp, io_rdata);
    chk("read valid", 8'h01, {7'h00, io_rdata_valid});
  endtask
  task automatic mem(input logic wr, input logic [15:0] a, input logic [2:0] exp);
    @(posedge clk) #1;
    cpu = '0;
    cpu.addr = a;
    cpu.mem_wr = wr;
    cpu.mem_rd = !wr;
    #1 chk("mem selects", {5'h00, exp}, {5'h00, boot_rom_sel, ram_rd_sel, ram_wr_sel});
    @(posedge clk) #1;
    cpu = '0;
  endtask
  task automatic t_mem;
    rdchk("sysctl reset", SYSTEM_CONTROL_PORT, 8'h00);
    mem(1'b0, 16'h0fff, 3'h4);
    mem(1'b0, 16'h1000, 3'h2);
    mem(1'b1, 16'h0000, 3'h1);
    mem(1'b1, 16'hffff, 3'h1);
    chk("beeper", 8'h00, {7'h00, beeper_on});
    io(1'b1, SYSTEM_CONTROL_PORT, 8'hc0);
    mem(1'b0, 16'h0000, 3'h2);
    chk("beeper", 8'h01, {7'h00, beeper_on});
    io(1'b1, SYSTEM_CONTROL_PORT, 8'h80);
    chk("beeper", 8'h00, {7'h00, beeper_on});
  endtask
  task automatic t_key;
    key_mods = 3'h5;
    @(posedge clk) #1;
    key_code = 7'h41;
    key_strobe = 1'b1;
    @(posedge clk) #1;
    key_code = 7'h22;
    rdchk("key status", KEYBOARD_STATUS_PORT, 8'hc1);
    key_strobe = 1'b0;
    rdchk("key code", KEYBOARD_CODE_PORT, 8'h41);
    key_mods = 3'h2;
    rdchk("key status", KEYBOARD_STATUS_PORT, 8'h02);
  endtask
  task automatic t_video;
    io(1'b1, CURSOR_COLUMN_PORT, 8'h4f);
    io(1'b1, CURSOR_LINE_PORT, 8'h17);
    rdchk("column", CURSOR_COLUMN_PORT, 8'h4f);
    rdchk("line", CURSOR_LINE_PORT, 8'h17);
    io(1'b0, VIDEO_STATUS_PORT, 8'h00);
    chk("ready", 8'h80, io_rdata & 8'h80);
    io(1'b1, VIDEO_WRITE_DATA_PORT, 8'ha5);
    chk("video data", 8'ha5, video_wr.data);
    chk("video place", 8'hcf, {video_wr.we, video_wr.column});
    chk("video line", 8'h17, {2'h0, video_wr.line});
    io(1'b0, VIDEO_STATUS_PORT, 8'h00);
    chk("busy", 8'h00, io_rdata & 8'h80);
  endtask
  task automatic t_dec;
    for (int a = 0; a < 256; a++) begin
      @(posedge clk) #1;
      cpu = '0;
      cpu.addr = 16'(a);
      cpu.io_rd = 1'b1;
      #1 chk("decode", {6'h00, a[7:4] == 4'h8, a[7:2] == 6'h02}, {6'h00, video_ctrl_sel, parallel_sel});
    end
    @(posedge clk) #1;
    cpu = '0;
    rdchk("unmapped", 8'h40, 8'hff);
    prn_in = 8'h3e;
    #1 chk("printer", 8'h02, prn_out);
    prn_in = 8'h3c;
    #1 chk("printer", 8'h00, prn_out);
  endtask
  task automatic report_and_stop;
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  initial begin
    #200000;
    n_errors++;
    report_and_stop;
  end
  initial begin
    repeat (12) @(posedge clk);
    #1 rst_n = 1'b1;
    t_mem;
    t_key;
    t_video;
    t_dec;
    report_and_stop;
  end
endmodule
